// ---- ipl_map.svh ----
// Register offsets, field positions, reset values and write masks of the priority registers.
`ifndef IPL_MAP_SVH
`define IPL_MAP_SVH
`define IPL_SERIAL_IDX 10'h006
`define IPL_PWM_IDX 10'h008
`define IPL_STATUS_IDX 10'h00a
`define IPL_SERIAL_RST 16'h0000
`define IPL_PWM_RST 16'h0000
`define IPL_STATUS_RST 16'h0000
`define IPL_SERIAL_WMASK 16'h0cff
`define IPL_PWM_WMASK 16'hff00
`define IPL_I2C0_LSB 10
`define IPL_SPI0_RX_LSB 6
`define IPL_SPI0_TX_LSB 4
`define IPL_SPI1_RX_LSB 2
`define IPL_SPI1_TX_LSB 0
`define IPL_PWM_CAP_LSB 14
`define IPL_PWM_RLD3_LSB 12
`define IPL_PWM_RERR_LSB 10
`define IPL_PWM_FAULT_LSB 8
`define IPL_NUM_SRC 9
`endif

// ---- ipl_pkg.sv ----
// Types and decode functions shared by the priority register block.
package ipl_pkg;
`include "ipl_map.svh"

	typedef enum logic [1:0] {
		IPL_MASKED = 2'b00,
		IPL_LEVEL0 = 2'b01,
		IPL_LEVEL1 = 2'b10,
		IPL_LEVEL2 = 2'b11
	} ipl_prio_t;

	typedef logic [`IPL_NUM_SRC-1:0] ipl_src_vec_t;
	typedef logic [2*`IPL_NUM_SRC-1:0] ipl_prio_vec_t;

	// One-hot contribution of a request to core levels 0..2; level 3 cannot be reached.
	function automatic logic [2:0] level_hit(input logic [1:0] code, input logic req);
		logic [2:0] hit;
		hit = 3'h0;
		unique case (ipl_prio_t'(code))
			IPL_MASKED: hit = 3'h0;
			IPL_LEVEL0: hit = {2'h0, req};
			IPL_LEVEL1: hit = {1'h0, req, 1'h0};
			IPL_LEVEL2: hit = {req, 2'h0};
		endcase
		return hit;
	endfunction

	function automatic logic [1:0] top_level(input logic [2:0] hit);
		logic [1:0] lvl;
		lvl = 2'h0;
		if (hit[2]) begin
			lvl = 2'h2;
		end else if (hit[1]) begin
			lvl = 2'h1;
		end
		return lvl;
	endfunction
endpackage

// ---- ipl_route_if.sv ----
// Carrier between the register block and the request router.
interface ipl_route_if;
	ipl_pkg::ipl_src_vec_t req;
	ipl_pkg::ipl_prio_vec_t prio;
	logic [2:0] level_hit;
	modport ctrl (output req, output prio, input level_hit);
	modport route (input req, input prio, output level_hit);
endinterface

// ---- ipl_route.sv ----
// Router that folds every gated request into the core level vector.
`include "ipl_map.svh"

module ipl_route (
	ipl_route_if.route rif
);
	always_comb begin
		logic [2:0] acc;
		acc = 3'h0;
		for (int i = 0; i < `IPL_NUM_SRC; i++) begin
			acc = acc | ipl_pkg::level_hit(rif.prio[2*i +: 2], rif.req[i]);
		end
		rif.level_hit = acc;
	end
endmodule // ipl_route

// ---- ipl_priority_regs.sv ----
// Priority level registers for serial and PWM requests, with an AHB-Lite slave port.
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`include "ipl_map.svh"

// Contract
// [RQ1] Code 00 masks, 01/10/11 give levels 0/1/2.
// [RQ2] Requests reach only levels 0 to 2.
// [RQ3] Reset clears every field to masked.
// [RQ4] Serial priority register at index 6.
// [RQ5] PWM priority register at index 8, resets zero.
// [RQ6] Serial register bits 15-12, 9-8 reserved.
// [RQ7] Bits 11-10 set I2C port 0 level.
// [RQ8] Bits 7-6 set SPI 0 receive-full level.
// [RQ9] Bits 5-4 set SPI 0 transmit-empty level.
// [RQ10] Bits 3-2 set SPI 1 receive-full level.
// [RQ11] A field sets SPI 1 transmit-empty level.
// [RQ12] That field sits in bits 1-0.
// [RQ13] PWM bits 15-14 set combined capture level.
// [RQ14] Combined capture ORs submodule 0-3 captures.
// [RQ15] PWM bits 13-12 set submodule 3 reload level.
// [RQ16] PWM bits 11-10 set reload-error level.
// [RQ17] PWM bits 9-8 set fault level; rest reserved.
module ipl_priority_regs (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic i2c_port0_request,
	input wire logic spi_port0_rx_full_request,
	input wire logic spi_port0_tx_empty_request,
	input wire logic spi_port1_rx_full_request,
	input wire logic spi_port1_tx_empty_request,
	input wire logic pwm_sub0_capture_request,
	input wire logic pwm_sub1_capture_request,
	input wire logic pwm_sub2_capture_request,
	input wire logic pwm_sub3_capture_request,
	input wire logic pwm_sub3_reload_request,
	input wire logic pwm_reload_error_request,
	input wire logic pwm_fault_request,
	output logic [2:0] core_level_req,
	output logic core_irq_valid,
	output logic [1:0] core_irq_level
);
	logic [15:0] serial_port_irq_priority_reg;
	logic [15:0] serial_port_irq_priority_next;
	logic [15:0] pwm_irq_priority_reg;
	logic [15:0] pwm_irq_priority_next;
	logic [15:0] status_reg;
	logic wr_pend_reg;
	logic [9:0] wr_idx_reg;
	logic [31:0] hrdata_reg;
	logic [2:0] core_level_reg;
	logic [1:0] core_top_reg;
	logic addr_accept;
	logic [9:0] addr_idx;
	logic pwm_capture_any;
	ipl_pkg::ipl_src_vec_t src_req;
	ipl_route_if rif ();

	// Zero wait states: every transfer finishes in its first data-phase cycle.
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;

	// Upper address bits must be zero for a hit, so the map does not alias.
	function automatic logic [9:0] word_index(input logic [31:0] a);
		return (a[31:12] == 20'h00000) ? a[11:2] : 10'h3ff;
	endfunction

	assign addr_accept = hsel && hready && htrans[1];
	assign addr_idx = word_index(haddr);

	// Write data arrives in the data phase; the next value is used both for the
	// update and for a read that follows back to back, so that read sees the write.
	always_comb begin
		serial_port_irq_priority_next = serial_port_irq_priority_reg;
		if (wr_pend_reg && wr_idx_reg == `IPL_SERIAL_IDX) begin // [RQ4]
			serial_port_irq_priority_next = hwdata[15:0] & `IPL_SERIAL_WMASK; // [RQ6]
		end
	end

	always_comb begin
		pwm_irq_priority_next = pwm_irq_priority_reg;
		if (wr_pend_reg && wr_idx_reg == `IPL_PWM_IDX) begin // [RQ5]
			pwm_irq_priority_next = hwdata[15:0] & `IPL_PWM_WMASK; // [RQ17]
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_idx_reg <= 10'h000;
		end else begin
			wr_pend_reg <= addr_accept && hwrite;
			if (addr_accept) begin
				wr_idx_reg <= addr_idx;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			serial_port_irq_priority_reg <= `IPL_SERIAL_RST; // [RQ3]
			pwm_irq_priority_reg <= `IPL_PWM_RST; // [RQ3] [RQ5]
		end else begin
			serial_port_irq_priority_reg <= serial_port_irq_priority_next;
			pwm_irq_priority_reg <= pwm_irq_priority_next;
		end
	end

	// Read data is latched at the end of the address phase and stands through the data phase.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_reg <= 32'h00000000;
		end else if (addr_accept && !hwrite) begin
			unique case (addr_idx)
				`IPL_SERIAL_IDX: hrdata_reg <= {16'h0000, serial_port_irq_priority_next};
				`IPL_PWM_IDX: hrdata_reg <= {16'h0000, pwm_irq_priority_next};
				`IPL_STATUS_IDX: hrdata_reg <= {16'h0000, status_reg};
				default: hrdata_reg <= 32'h00000000;
			endcase
		end
	end

	assign pwm_capture_any = pwm_sub0_capture_request | pwm_sub1_capture_request
		| pwm_sub2_capture_request | pwm_sub3_capture_request; // [RQ14]

	assign src_req = {pwm_fault_request, pwm_reload_error_request, pwm_sub3_reload_request,
		pwm_capture_any, spi_port1_tx_empty_request, spi_port1_rx_full_request,
		spi_port0_tx_empty_request, spi_port0_rx_full_request, i2c_port0_request};

	assign rif.req = src_req;
	assign rif.prio = {
		pwm_irq_priority_reg[`IPL_PWM_FAULT_LSB +: 2], // [RQ17]
		pwm_irq_priority_reg[`IPL_PWM_RERR_LSB +: 2], // [RQ16]
		pwm_irq_priority_reg[`IPL_PWM_RLD3_LSB +: 2], // [RQ15]
		pwm_irq_priority_reg[`IPL_PWM_CAP_LSB +: 2], // [RQ13]
		serial_port_irq_priority_reg[`IPL_SPI1_TX_LSB +: 2], // [RQ11] [RQ12]
		serial_port_irq_priority_reg[`IPL_SPI1_RX_LSB +: 2], // [RQ10]
		serial_port_irq_priority_reg[`IPL_SPI0_TX_LSB +: 2], // [RQ9]
		serial_port_irq_priority_reg[`IPL_SPI0_RX_LSB +: 2], // [RQ8]
		serial_port_irq_priority_reg[`IPL_I2C0_LSB +: 2] // [RQ7]
	};

	// Each unmasked field gates its request onto exactly one of levels 0..2.
	ipl_route u_route (
		.rif(rif.route) // [RQ1] [RQ2]
	);

	// Raw request snapshot, readable by software to see which sources are asking.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_reg <= `IPL_STATUS_RST;
		end else begin
			status_reg <= {7'h00, src_req};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			core_level_reg <= 3'h0;
			core_top_reg <= 2'h0;
		end else begin
			core_level_reg <= rif.level_hit;
			core_top_reg <= ipl_pkg::top_level(rif.level_hit); // [RQ2]
		end
	end

	assign core_level_req = core_level_reg;
	assign core_irq_valid = |core_level_reg;
	assign core_irq_level = core_top_reg;

	// Checks on the visible behaviour.

	reset_clear_a: assert property ( // [RQ3]
		@(posedge hclk)
		$rose(hresetn) |->
			serial_port_irq_priority_reg == 16'h0000 && pwm_irq_priority_reg == 16'h0000
	) else $error("priority fields not cleared at reset release");

	all_masked_a: assert property ( // [RQ1]
		@(posedge hclk) disable iff (!hresetn)
		(serial_port_irq_priority_reg == 16'h0000 && pwm_irq_priority_reg == 16'h0000)
			|=> core_level_req == 3'h0
	) else $error("request passed while every field is masked");

	no_level3_a: assert property ( // [RQ2]
		@(posedge hclk) disable iff (!hresetn)
		core_irq_valid |-> core_irq_level != 2'h3 && core_level_req[core_irq_level]
	) else $error("core level out of range or not pending");

	reserved_zero_a: assert property ( // [RQ6]
		@(posedge hclk) disable iff (!hresetn)
		serial_port_irq_priority_reg[15:12] == 4'h0
			&& serial_port_irq_priority_reg[9:8] == 2'h0
			&& pwm_irq_priority_reg[7:0] == 8'h00
	) else $error("reserved priority bits became set");

	serial_write_a: assert property ( // [RQ4]
		@(posedge hclk) disable iff (!hresetn)
		(addr_accept && hwrite && haddr == 32'h00000018)
			##1 1'b1 |=> serial_port_irq_priority_reg == ($past(hwdata[15:0]) & 16'h0cff)
	) else $error("write at serial register address not stored");

	pwm_write_a: assert property ( // [RQ5]
		@(posedge hclk) disable iff (!hresetn)
		(addr_accept && hwrite && haddr == 32'h00000020)
			##1 1'b1 |=> pwm_irq_priority_reg == ($past(hwdata[15:0]) & 16'hff00)
	) else $error("write at pwm register address not stored");

	i2c_level_a: assert property ( // [RQ7]
		@(posedge hclk) disable iff (!hresetn)
		(i2c_port0_request && serial_port_irq_priority_reg[11:10] == 2'b11)
			|=> core_level_req[2]
	) else $error("i2c request not raised at level 2");

	spi0_rx_a: assert property ( // [RQ8]
		@(posedge hclk) disable iff (!hresetn)
		(spi_port0_rx_full_request && serial_port_irq_priority_reg[7:6] == 2'b01)
			|=> core_level_req[0]
	) else $error("spi 0 receive request not raised at level 0");

	spi0_tx_a: assert property ( // [RQ9]
		@(posedge hclk) disable iff (!hresetn)
		(spi_port0_tx_empty_request && serial_port_irq_priority_reg[5:4] == 2'b10)
			|=> core_level_req[1]
	) else $error("spi 0 transmit request not raised at level 1");

	spi1_rx_a: assert property ( // [RQ10]
		@(posedge hclk) disable iff (!hresetn)
		(spi_port1_rx_full_request && serial_port_irq_priority_reg[3:2] == 2'b11)
			|=> core_level_req[2]
	) else $error("spi 1 receive request not raised at level 2");

	spi1_tx_a: assert property ( // [RQ11] [RQ12]
		@(posedge hclk) disable iff (!hresetn)
		(spi_port1_tx_empty_request && serial_port_irq_priority_reg[1:0] == 2'b01)
			|=> core_level_req[0]
	) else $error("spi 1 transmit request not raised at level 0");

	capture_or_a: assert property ( // [RQ13] [RQ14]
		@(posedge hclk) disable iff (!hresetn)
		(pwm_sub3_capture_request && pwm_irq_priority_reg[15:14] == 2'b10)
			|=> core_level_req[1]
	) else $error("submodule 3 capture not raised at level 1");

	reload3_a: assert property ( // [RQ15]
		@(posedge hclk) disable iff (!hresetn)
		(pwm_sub3_reload_request && pwm_irq_priority_reg[13:12] == 2'b11)
			|=> core_level_req[2]
	) else $error("reload request not raised at level 2");

	reload_err_a: assert property ( // [RQ16]
		@(posedge hclk) disable iff (!hresetn)
		(pwm_reload_error_request && pwm_irq_priority_reg[11:10] == 2'b01)
			|=> core_level_req[0]
	) else $error("reload error not raised at level 0");

	fault_level_a: assert property ( // [RQ17]
		@(posedge hclk) disable iff (!hresetn)
		(pwm_fault_request && pwm_irq_priority_reg[9:8] == 2'b10)
			|=> core_level_req[1]
	) else $error("fault request not raised at level 1");

	read_back_a: assert property ( // [RQ4]
		@(posedge hclk) disable iff (!hresetn)
		(addr_accept && !hwrite && haddr == 32'h00000018 && !wr_pend_reg)
			|=> hrdata == {16'h0000, $past(serial_port_irq_priority_reg)}
	) else $error("serial register read returned wrong data");

	// Single-source checks pin down the whole level vector, not just one bit of it.
	i2c_masked_a: assert property ( // [RQ1]
		@(posedge hclk) disable iff (!hresetn)
		(src_req == 9'h001 && serial_port_irq_priority_reg[11:10] == 2'b00)
			|=> core_level_req == 3'h0
	) else $error("masked i2c request reached the core");

	i2c_level0_a: assert property ( // [RQ1]
		@(posedge hclk) disable iff (!hresetn)
		(src_req == 9'h001 && serial_port_irq_priority_reg[11:10] == 2'b01)
			|=> core_level_req == 3'h1 && core_irq_level == 2'h0
	) else $error("i2c request not raised at level 0 alone");

	i2c_level1_a: assert property ( // [RQ1]
		@(posedge hclk) disable iff (!hresetn)
		(src_req == 9'h001 && serial_port_irq_priority_reg[11:10] == 2'b10)
			|=> core_level_req == 3'h2 && core_irq_level == 2'h1
	) else $error("i2c request not raised at level 1 alone");

	fault_masked_a: assert property ( // [RQ17]
		@(posedge hclk) disable iff (!hresetn)
		(src_req == 9'h100 && pwm_irq_priority_reg[9:8] == 2'b00)
			|=> core_level_req == 3'h0
	) else $error("masked fault request reached the core");

	capture_low_a: assert property ( // [RQ14]
		@(posedge hclk) disable iff (!hresetn)
		((pwm_sub0_capture_request || pwm_sub1_capture_request || pwm_sub2_capture_request)
			&& pwm_irq_priority_reg[15:14] == 2'b11) |=> core_level_req[2]
	) else $error("lower submodule capture not raised at level 2");

	top_level_a: assert property ( // [RQ2]
		@(posedge hclk) disable iff (!hresetn)
		core_level_req[2] |-> core_irq_level == 2'h2
	) else $error("level 2 pending but not reported as highest");

	mid_level_a: assert property ( // [RQ2]
		@(posedge hclk) disable iff (!hresetn)
		(core_level_req[1] && !core_level_req[2]) |-> core_irq_level == 2'h1
	) else $error("level 1 pending but not reported as highest");

	idle_level_a: assert property ( // [RQ2]
		@(posedge hclk) disable iff (!hresetn)
		!core_irq_valid |-> core_irq_level == 2'h0
	) else $error("level reported while nothing is pending");

	reset_outputs_a: assert property ( // [RQ3]
		@(posedge hclk)
		$rose(hresetn) |->
			core_level_req == 3'h0 && core_irq_level == 2'h0 && hrdata == 32'h00000000
	) else $error("outputs not cleared at reset release");

	pwm_read_a: assert property ( // [RQ5]
		@(posedge hclk) disable iff (!hresetn)
		(addr_accept && !hwrite && haddr == 32'h00000020 && !wr_pend_reg)
			|=> hrdata == {16'h0000, $past(pwm_irq_priority_reg)}
	) else $error("pwm register read returned wrong data");

	unmapped_read_a: assert property ( // [RQ4] [RQ5]
		@(posedge hclk) disable iff (!hresetn)
		(addr_accept && !hwrite && haddr[11:2] != 10'h006 && haddr[11:2] != 10'h008
			&& haddr[11:2] != 10'h00a) |=> hrdata == 32'h00000000
	) else $error("unmapped read returned nonzero data");

	// An alias above the map must not reach a priority register.
	stray_write_a: assert property ( // [RQ4] [RQ5]
		@(posedge hclk) disable iff (!hresetn)
		(addr_accept && hwrite && !(haddr[31:12] == 20'h00000 && haddr[11:2] == 10'h006)
			&& !(haddr[31:12] == 20'h00000 && haddr[11:2] == 10'h008)) ##1 1'b1
			|=> $stable(serial_port_irq_priority_reg) && $stable(pwm_irq_priority_reg)
	) else $error("write outside the registers changed a priority field");

endmodule // ipl_priority_regs

// ---- ipl_src_model.sv ----
// Behavioural model of the peripheral request sources feeding the priority block.
module ipl_src_model (
	input wire logic [11:0] pattern,
	output logic i2c0,
	output logic spi0_rx,
	output logic spi0_tx,
	output logic spi1_rx,
	output logic spi1_tx,
	output logic [3:0] cap,
	output logic reload3,
	output logic reload_err,
	output logic fault
);
	timeunit 1ns;
	timeprecision 1ps;
	// Each source holds a level request for as long as the bench pattern asks.
	assign {fault, reload_err, reload3, cap, spi1_tx, spi1_rx, spi0_tx, spi0_rx, i2c0} = pattern;
endmodule // ipl_src_model

// ---- ipl_priority_regs_tb_top.sv ----
// Self-checking bench for the priority level registers.
module ipl_priority_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk = 0, hresetn, hsel, hwrite;
	logic [31:0] haddr, hwdata, hrdata, seed, d, e, g, ra, rm;
	logic [5:0] lv_exp;
	logic [1:0] htrans, obs, lvl;
	logic [2:0] hsize, lreq;
	logic [11:0] rq;
	logic [3:0] cap;
	logic hreadyout, hready, hresp, vld, i2c0, s0r, s0t, s1r, s1t, rl3, rer, flt;
	logic [31:0] q[$];
	int mismatches = 0, n_tests = 0, b;
	int lsb[9] = '{10, 6, 4, 2, 0, 14, 12, 10, 8};
	always #20 hclk = ~hclk;
	assign hready = hreadyout;
	ipl_src_model src_u (.pattern(rq), .i2c0(i2c0), .spi0_rx(s0r), .spi0_tx(s0t),
		.spi1_rx(s1r), .spi1_tx(s1t), .cap(cap), .reload3(rl3), .reload_err(rer), .fault(flt));
	ipl_priority_regs dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .i2c_port0_request(i2c0),
		.spi_port0_rx_full_request(s0r), .spi_port0_tx_empty_request(s0t),
		.spi_port1_rx_full_request(s1r), .spi_port1_tx_empty_request(s1t),
		.pwm_sub0_capture_request(cap[0]), .pwm_sub1_capture_request(cap[1]),
		.pwm_sub2_capture_request(cap[2]), .pwm_sub3_capture_request(cap[3]),
		.pwm_sub3_reload_request(rl3), .pwm_reload_error_request(rer),
		.pwm_fault_request(flt), .core_level_req(lreq), .core_irq_valid(vld),
		.core_irq_level(lvl));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Results are compared mid-cycle, where the outputs have settled.
	always @(negedge hclk) begin
		if (obs != 2'h0) begin
			e = q.pop_front();
			g = (obs == 2'h1) ? hrdata : {26'h0, vld, lvl, lreq};
			n_tests++;
			if (g !== e) begin
				mismatches++;
				$display("Error t=%0t exp=%h got=%h", $time, e, g);
			end
			if (obs == 2'h1 && hresp !== 1'b0) begin
				mismatches++;
				$display("Error t=%0t exp=%h got=%h", $time, 1'b0, hresp);
			end
		end
	end

	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] dd,
		input logic [31:0] ee);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		hsize <= 3'h2;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= dd;
		if (!w) begin
			q.push_back(ee);
			obs <= 2'h1;
		end
		do @(posedge hclk); while (hready !== 1'b1);
		obs <= 2'h0;
	endtask

	// Requests are registered, so the answer is looked at one edge after they rise.
	task automatic lv(input logic [11:0] r, input logic [5:0] ee);
		@(posedge hclk);
		rq <= r;
		@(posedge hclk);
		q.push_back({26'h0, ee});
		obs <= 2'h2;
		@(posedge hclk);
		obs <= 2'h0;
		rq <= 12'h0;
	endtask

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge hclk);
		mismatches++;
		test_done();
	end

	initial begin
		hresetn = 0; hsel = 0; haddr = 32'h0; htrans = 2'h0; hwrite = 0; hsize = 3'h0;
		hwdata = 32'h0; rq = 12'h0; obs = 2'h0; seed = 32'he599a8fe;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(1'b0, 32'h18, 32'h0, 32'h0);
		ahb(1'b0, 32'h20, 32'h0, 32'h0);
		ahb(1'b1, 32'h18, 32'hffffffff, 32'h0);
		ahb(1'b0, 32'h18, 32'h0, 32'h0cff);
		ahb(1'b1, 32'h20, 32'hffffffff, 32'h0);
		ahb(1'b0, 32'h20, 32'h0, 32'hff00);
		ahb(1'b0, 32'h100, 32'h0, 32'h0);
		// Stray writes: an alias above the map, the read-only status word, an unmapped word.
		ahb(1'b1, 32'h1018, 32'h0, 32'h0);
		ahb(1'b1, 32'h28, 32'h0, 32'h0);
		ahb(1'b1, 32'h100, 32'h0, 32'h0);
		ahb(1'b0, 32'h18, 32'h0, 32'h0cff);
		ahb(1'b0, 32'h20, 32'h0, 32'hff00);
		// Status shows the requests of the cycle before the read; two captures fold to one bit.
		@(posedge hclk);
		rq <= 12'h0a5;
		ahb(1'b0, 32'h28, 32'h0, 32'h25);
		rq <= 12'h0;
		$display("test registers done");
		// Other fields get random codes; their sources stay quiet so only one path counts.
		for (int i = 0; i < 9; i++) begin
			for (int c = 0; c < 4; c++) begin
				seed = lfsr(seed);
				d = seed;
				d[lsb[i] +: 2] = c[1:0];
				ra = (i < 5) ? 32'h18 : 32'h20;
				rm = (i < 5) ? 32'h0cff : 32'hff00;
				ahb(1'b1, ra, d, 32'h0);
				ahb(1'b0, ra, 32'h0, d & rm);
				b = (i < 5) ? i : ((i == 5) ? 5 + int'(seed[1:0]) : i + 3);
				lv_exp = (c == 0) ? 6'h0 : {1'b1, 2'(c - 1), 3'(1 << (c - 1))};
				lv(12'(1 << b), lv_exp);
			end
		end
		$display("test levels done");
		@(posedge hclk);
		hresetn <= 1'b0;
		@(posedge hclk);
		hresetn <= 1'b1;
		lv(12'hfff, 6'h0);
		ahb(1'b0, 32'h18, 32'h0, 32'h0);
		ahb(1'b0, 32'h20, 32'h0, 32'h0);
		$display("test second reset done");
		test_done();
	end
endmodule // ipl_priority_regs_tb_top
